// ### design/lcfr_defines.vh
`ifndef LCFR_DEFINES_VH
`define LCFR_DEFINES_VH

`define LCFR_OFS_FAIRNESS 8'hDC
`define LCFR_OFS_LC_SET 8'hE0
`define LCFR_OFS_LC_CLR 8'hE4
`define LCFR_OFS_CYC_TIMER 8'hF0

`define LCFR_FAIR_RESET 8'h00
`define LCFR_BIT_SOURCE 22
`define LCFR_BIT_MASTER 21
`define LCFR_BIT_TIMER 20
`define LCFR_BIT_PHYPKT 10
`define LCFR_BIT_SELFID 9
`define LCFR_BIT_LOCK 6
`define LCFR_LC_WR_MASK 32'h0070_0640

`define LCFR_CYCLE_COUNTS 12'hC00
`define LCFR_OFFSET_RESET 12'h000
`define LCFR_CNT_RESET 7'h00

`endif

// ### design/lcfr_cycle_timer.v
`timescale 1ns/1ps
`include "lcfr_defines.vh"

module lcfr_cycle_timer (
  input wire clock_i,            // Core clock.
  input wire srst_i,             // Synchronous reset.
  input wire tick_i,             // One pulse per 24.576 MHz period.
  input wire enable_i,           // Counting enabled.
  input wire ext_source_i,       // Roll on external input.
  input wire ext_event_i,        // External cycle event pulse.
  input wire sync_i,             // Received cycle start resynchronises.
  output reg [11:0] offset_o,    // Cycle offset.
  output reg [6:0] seconds_o,    // Cycle count wraps at 128.
  output reg rollover_o          // One-cycle rollover pulse.
);

  wire internal_roll = (offset_o == `LCFR_CYCLE_COUNTS - 12'd1) && tick_i;
  wire roll = enable_i && (ext_source_i ? ext_event_i : internal_roll);

  always @(posedge clock_i) begin
    if (srst_i) begin
      offset_o <= `LCFR_OFFSET_RESET;
      seconds_o <= `LCFR_CNT_RESET;
      rollover_o <= 1'b0;
    end else begin
      rollover_o <= roll;
      if (sync_i) begin
        offset_o <= `LCFR_OFFSET_RESET; // R7
      end else if (roll) begin
        offset_o <= `LCFR_OFFSET_RESET; // R4 R5
        seconds_o <= seconds_o + 7'd1;
      end else if (enable_i && tick_i && !internal_roll) begin
        offset_o <= offset_o + 12'd1; // R10
      end
    end
  end

endmodule

// ### design/lcfr_fairness_limiter.v
`timescale 1ns/1ps

module lcfr_fairness_limiter (
  input wire clock_i,            // Core clock.
  input wire srst_i,             // Synchronous reset.
  input wire [7:0] limit_i,      // Requests allowed per interval.
  input wire interval_start_i,   // New fairness interval begins.
  input wire req_i,              // Link wants a priority request.
  output wire grant_o,           // Request may go to the physical layer.
  output reg [7:0] used_o        // Requests already made this interval.
);

  // A limit of zero forbids priority requests entirely.
  assign grant_o = req_i && (used_o < limit_i); // R2

  always @(posedge clock_i) begin
    if (srst_i || interval_start_i) begin
      used_o <= 8'h00;
    end else if (grant_o) begin
      used_o <= used_o + 8'h01;
    end
  end

endmodule

// ### design/lcfr_regs.v
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "lcfr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - Fairness bits 31-8 read zero.
// R2 - Priority request limit field, read/write, reset zero.
// R3 - Link control at set and clear offsets.
// R4 - Source bit set: roll on external input.
// R5 - Source bit clear: roll after 3072 counts.
// R6 - Master and root: send cycle start.
// R7 - Not root: accept received cycle starts.
// R8 - Overlong cycle event clears master bit.
// R9 - Master set ignored while event pending.
// R10 - Timer enable counts, otherwise offset holds.
// R11 - PHY packets accepted when bit and context.
// R12 - Self-ID bit enables self-ID reception.
// R13 - Software loads self-ID pointer first.
// R14 - Lock forces tag-one filter bit high.
// R15 - Lock cleared only by fundamental resets.
// R16 - Reserved link control bits read zero.
// R17 - Reset clears defined link control bits.
// R18 - Fairness register at its own offset.
// R19 - Ones set or clear; zeros ignored.
// R20 - Reserved bits unaffected by set/clear.
module lcfr_regs (
  input wire clock_i,                 // Core clock, 10 MHz.
  input wire srst_i,                  // Synchronous reset, active high.
  input wire fundamental_reset_n_i,   // Fundamental reset, active low.
  input wire platform_reset_n_i,      // Platform reset, active low.
  input wire [7:0] addr_i,            // Register byte address.
  input wire [31:0] wdata_i,          // Write data.
  input wire wr_i,                    // Write strobe.
  input wire rd_i,                    // Read strobe.
  output reg [31:0] rdata_o,          // Read data, cycle after strobe.
  input wire tick_i,                  // 24.576 MHz count pulse.
  input wire external_cycle_input_i,  // External cycle event pulse.
  input wire node_root_i,             // Node is root.
  input wire cycle_start_rx_i,        // Cycle start packet received.
  input wire overlong_cycle_event_i,  // Overlong cycle event flag level.
  input wire async_receive_enable_i,  // Request receive context running.
  input wire phy_packet_rx_i,         // PHY packet arrived.
  input wire self_id_rx_i,            // Self-ID packet arrived.
  input wire tag_one_sync_filter_i,   // Software filter bit value.
  input wire prio_req_i,              // Link wants priority request.
  input wire interval_start_i,        // Fairness interval begins.
  output wire prio_grant_o,           // Priority request permitted.
  output reg cycle_start_tx_o,        // Send cycle start packet.
  output reg store_phy_packet_o,      // Store PHY packet.
  output reg store_self_id_o,         // Store self-ID packet.
  output wire tag_one_sync_filter_o,  // Effective filter bit.
  output wire [11:0] cycle_offset_o   // Cycle timer offset.
);

  ////////////////////////////////////////////////////////////////////////////////
  reg [7:0] fair_limit_ff;
  reg rollover_source_select_ff;
  reg cycle_master_enable_ff;
  reg timer_count_enable_ff;
  reg accept_phy_packets_ff;
  reg accept_self_identification_ff;
  reg filter_lock_ff;
  reg overlong_prev_ff;
  wire [6:0] cycle_count;
  wire rollover;
  wire [7:0] used_count;

  wire wr_fair = wr_i && (addr_i == `LCFR_OFS_FAIRNESS); // R18
  wire wr_set = wr_i && (addr_i == `LCFR_OFS_LC_SET);    // R3
  wire wr_clr = wr_i && (addr_i == `LCFR_OFS_LC_CLR);    // R3
  // Only the documented writable bits take part; others are dropped.
  wire [31:0] set_bits = wr_set ? (wdata_i & `LCFR_LC_WR_MASK) : 32'h0000_0000; // R20
  wire [31:0] clr_bits = wr_clr ? (wdata_i & `LCFR_LC_WR_MASK) : 32'h0000_0000; // R20
  wire overlong_rise = overlong_cycle_event_i && !overlong_prev_ff;

  wire [31:0] link_ctrl = {9'h000, rollover_source_select_ff, cycle_master_enable_ff,
                           timer_count_enable_ff, 9'h000, accept_phy_packets_ff,
                           accept_self_identification_ff, 2'b00, filter_lock_ff,
                           6'h00}; // R16

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    if (srst_i) begin
      fair_limit_ff <= `LCFR_FAIR_RESET; // R2
    end else if (wr_fair) begin
      fair_limit_ff <= wdata_i[7:0]; // R2
    end
  end

  // Undefined reset bits are cleared to zero for determinism.
  always @(posedge clock_i) begin
    if (srst_i) begin
      rollover_source_select_ff <= 1'b0; // R17
      cycle_master_enable_ff <= 1'b0;
      timer_count_enable_ff <= 1'b0;
      accept_phy_packets_ff <= 1'b0;
      accept_self_identification_ff <= 1'b0;
      overlong_prev_ff <= 1'b0;
    end else begin
      overlong_prev_ff <= overlong_cycle_event_i;
      if (set_bits[`LCFR_BIT_SOURCE]) begin
        rollover_source_select_ff <= 1'b1; // R19
      end else if (clr_bits[`LCFR_BIT_SOURCE]) begin
        rollover_source_select_ff <= 1'b0;
      end
      // Hardware clear wins; a set is refused while the event stands.
      if (overlong_rise || overlong_cycle_event_i) begin
        cycle_master_enable_ff <= 1'b0; // R8 R9
      end else if (set_bits[`LCFR_BIT_MASTER]) begin
        cycle_master_enable_ff <= 1'b1;
      end else if (clr_bits[`LCFR_BIT_MASTER]) begin
        cycle_master_enable_ff <= 1'b0;
      end
      if (set_bits[`LCFR_BIT_TIMER]) begin
        timer_count_enable_ff <= 1'b1;
      end else if (clr_bits[`LCFR_BIT_TIMER]) begin
        timer_count_enable_ff <= 1'b0;
      end
      if (set_bits[`LCFR_BIT_PHYPKT]) begin
        accept_phy_packets_ff <= 1'b1;
      end else if (clr_bits[`LCFR_BIT_PHYPKT]) begin
        accept_phy_packets_ff <= 1'b0;
      end
      if (set_bits[`LCFR_BIT_SELFID]) begin
        accept_self_identification_ff <= 1'b1;
      end else if (clr_bits[`LCFR_BIT_SELFID]) begin
        accept_self_identification_ff <= 1'b0;
      end
    end
  end

  // The lock survives the ordinary reset and any clear write.
  always @(posedge clock_i) begin
    if (!fundamental_reset_n_i || !platform_reset_n_i) begin
      filter_lock_ff <= 1'b0; // R15
    end else if (set_bits[`LCFR_BIT_LOCK]) begin
      filter_lock_ff <= 1'b1; // R15
    end
  end

  assign tag_one_sync_filter_o = filter_lock_ff | tag_one_sync_filter_i; // R14

  ////////////////////////////////////////////////////////////////////////////////
  lcfr_cycle_timer u_timer (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .tick_i(tick_i),
    .enable_i(timer_count_enable_ff),
    .ext_source_i(rollover_source_select_ff),
    .ext_event_i(external_cycle_input_i),
    .sync_i(cycle_start_rx_i && !node_root_i),
    .offset_o(cycle_offset_o),
    .seconds_o(cycle_count),
    .rollover_o(rollover)
  );

  lcfr_fairness_limiter u_fair (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .limit_i(fair_limit_ff),
    .interval_start_i(interval_start_i),
    .req_i(prio_req_i),
    .grant_o(prio_grant_o),
    .used_o(used_count)
  );

  always @(posedge clock_i) begin
    if (srst_i) begin
      cycle_start_tx_o <= 1'b0;
      store_phy_packet_o <= 1'b0;
      store_self_id_o <= 1'b0;
    end else begin
      cycle_start_tx_o <= rollover && cycle_master_enable_ff && node_root_i; // R6
      store_phy_packet_o <= phy_packet_rx_i && accept_phy_packets_ff
                            && async_receive_enable_i; // R11
      store_self_id_o <= self_id_rx_i && accept_self_identification_ff; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Unmapped addresses read zero.
  always @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        `LCFR_OFS_FAIRNESS: rdata_o <= {24'h00_0000, fair_limit_ff}; // R1
        `LCFR_OFS_LC_SET: rdata_o <= link_ctrl; // R19
        `LCFR_OFS_LC_CLR: rdata_o <= link_ctrl; // R19
        `LCFR_OFS_CYC_TIMER: rdata_o <= {used_count, 5'h00, cycle_count, cycle_offset_o};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// ### bench/lcfr_regs_properties.sv
`timescale 1ns/1ps
module lcfr_regs_properties (
  input wire clock_i, // Clock.
  input wire srst_i, // Reset.
  input wire [7:0] addr_i, // Address.
  input wire rd_i, // Read.
  input wire [31:0] rdata_o, // Data.
  input wire tick_i, // Tick.
  input wire external_cycle_input_i, // Ext.
  input wire node_root_i, // Root.
  input wire cycle_start_rx_i, // Sync.
  input wire overlong_cycle_event_i, // Flag.
  input wire async_receive_enable_i, // Ctx.
  input wire phy_packet_rx_i, // PHY.
  input wire self_id_rx_i, // Self-ID.
  input wire fundamental_reset_n_i, // Rst.
  input wire platform_reset_n_i, // Rst.
  input wire tag_one_sync_filter_i, // Filt.
  input wire tag_one_sync_filter_o, // Filt.
  input wire cycle_start_tx_o, // Tx.
  input wire store_phy_packet_o, // PHY.
  input wire store_self_id_o, // SID.
  input wire [11:0] cycle_offset_o // Off.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  fair_rsvd_a: assert property ($past(rd_i && addr_i == 8'hDC) |->
    rdata_o[31:8] == 24'h00_0000) else $error("fairness upper bits set");
  lc_rsvd_a: assert property ($past(rd_i && addr_i[7:3] == 5'h1C) |->
    (rdata_o & 32'hFF8F_F9BF) == 32'h0000_0000) else $error("link reserved bit set");
  master_blocked_a: assert property ($past(overlong_cycle_event_i, 2) &&
    $past(overlong_cycle_event_i && rd_i && addr_i[7:3] == 5'h1C) |-> !rdata_o[21])
    else $error("master bit set during overlong");
  filter_force_a: assert property ($past(rd_i && addr_i == 8'hE0) && rdata_o[6]
    |-> tag_one_sync_filter_o) else $error("filter not forced");
  lock_kept_a: assert property ($past(fundamental_reset_n_i && platform_reset_n_i &&
    tag_one_sync_filter_o && !tag_one_sync_filter_i) && !tag_one_sync_filter_i
    |-> tag_one_sync_filter_o) else $error("lock lost");
  phy_store_a: assert property (store_phy_packet_o |->
    $past(phy_packet_rx_i && async_receive_enable_i)) else $error("stray phy store");
  sid_store_a: assert property (store_self_id_o |-> $past(self_id_rx_i))
    else $error("stray self-id store");
  start_root_a: assert property (cycle_start_tx_o |-> $past(node_root_i))
    else $error("cycle start while not root");
  offset_hold_a: assert property ($changed(cycle_offset_o) |->
    $past(tick_i || cycle_start_rx_i || external_cycle_input_i)) else $error("offset moved");
  cover property (cycle_start_tx_o);
  cover property (store_self_id_o);
  cover property ($past(rd_i && addr_i == 8'hDC));
endmodule
bind lcfr_regs lcfr_regs_properties i_props (.*);

// ### bench/lcfr_phy_model.sv
`timescale 1ns/1ps
// Far side: the count tick runs free, packets arrive one cycle after a request.
module lcfr_phy_model (
  input wire clock_i, // Clock.
  input wire [2:0] send_i, // PHY, self-ID, cycle start requests.
  output reg tick_o = 1'h0, // Count pulse.
  output reg [2:0] rx_o = 3'h0 // Arrival pulses.
);
  always @(posedge clock_i) begin
    tick_o <= ~tick_o;
    rx_o <= send_i;
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  reg clock_i = 1'h0;
  reg srst_i = 1'h1;
  reg fundamental_reset_n_i = 1'h1;
  reg platform_reset_n_i = 1'h0;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wdata_i = 32'h0000_0000;
  reg wr_i = 1'h0;
  reg rd_i = 1'h0;
  reg external_cycle_input_i = 1'h0;
  reg node_root_i = 1'h1;
  reg overlong_cycle_event_i = 1'h0;
  reg async_receive_enable_i = 1'h1;
  reg tag_one_sync_filter_i = 1'h0;
  reg prio_req_i = 1'h0;
  reg interval_start_i = 1'h0;
  reg [2:0] send = 3'h0;
  reg [11:0] held;
  wire tick_i, phy_packet_rx_i, self_id_rx_i, cycle_start_rx_i, prio_grant_o;
  wire cycle_start_tx_o, store_phy_packet_o, store_self_id_o, tag_one_sync_filter_o;
  wire [31:0] rdata_o;
  wire [11:0] cycle_offset_o;
  integer n_mismatch = 0, compares = 0, n_grant = 0, n_cs = 0, n_phy = 0, n_sid = 0;
  always #50 clock_i = ~clock_i;
  lcfr_regs i_dut (.*);
  lcfr_phy_model i_phy (.clock_i(clock_i), .send_i(send), .tick_o(tick_i),
    .rx_o({phy_packet_rx_i, self_id_rx_i, cycle_start_rx_i}));
  always @(posedge clock_i) begin
    n_grant <= n_grant + prio_grant_o;
    n_cs <= n_cs + cycle_start_tx_o;
    n_phy <= n_phy + store_phy_packet_o;
    n_sid <= n_sid + store_self_id_o;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Strobes drop for one cycle between accesses so no signal is driven twice at one edge.
  task wr(input [7:0] a, input [31:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
      @(posedge clock_i);
      wr_i <= 1'h0;
      @(posedge clock_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      addr_i <= a;
      rd_i <= 1'h1;
      @(posedge clock_i);
      rd_i <= 1'h0;
      #1 chk(rdata_o, exp);
      @(posedge clock_i);
    end
  endtask
  task pulse(input [2:0] s);
    begin
      send <= s;
      @(posedge clock_i);
      send <= 3'h0;
      @(posedge clock_i);
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'h0;
    // The lock bit ignores the ordinary reset, so the platform reset must clear it first.
    platform_reset_n_i <= 1'h1;
    @(posedge clock_i);
    rd(8'hDC, 32'h0000_0000);
    rd(8'hE0, 32'h0000_0000);
    wr(8'hDC, 32'hFFFF_FFFF);
    rd(8'hDC, 32'h0000_00FF);
    wr(8'hDC, 32'h0000_0002);
    interval_start_i <= 1'h1;
    @(posedge clock_i);
    interval_start_i <= 1'h0;
    prio_req_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    prio_req_i <= 1'h0;
    #1 chk(n_grant, 2);
    $display("fairness test done");
    wr(8'hE0, 32'hFFFF_FFFF);
    rd(8'hE4, 32'h0070_0640);
    chk(tag_one_sync_filter_o, 1);
    pulse(3'h6);
    wr(8'hE4, 32'hFFFF_FFFF);
    rd(8'hE0, 32'h0000_0040);
    pulse(3'h6);
    @(posedge clock_i);
    #1 chk(n_phy, 1);
    chk(n_sid, 1);
    fundamental_reset_n_i <= 1'h0;
    @(posedge clock_i);
    fundamental_reset_n_i <= 1'h1;
    rd(8'hE0, 32'h0000_0000);
    chk(tag_one_sync_filter_o, 0);
    wr(8'hE0, 32'h0020_0000);
    rd(8'hE4, 32'h0020_0000);
    overlong_cycle_event_i <= 1'h1;
    @(posedge clock_i);
    rd(8'hE4, 32'h0000_0000);
    wr(8'hE0, 32'h0020_0000);
    rd(8'hE4, 32'h0000_0000);
    overlong_cycle_event_i <= 1'h0;
    $display("control test done");
    wr(8'hE0, 32'h0030_0000);
    repeat (20) @(posedge clock_i);
    #1 chk(cycle_offset_o != 12'h000, 1);
    wr(8'hE4, 32'h0010_0000);
    #1 held = cycle_offset_o;
    repeat (10) @(posedge clock_i);
    #1 chk(cycle_offset_o, held);
    node_root_i <= 1'h0;
    pulse(3'h1);
    #1 chk(cycle_offset_o, 0);
    node_root_i <= 1'h1;
    wr(8'hE0, 32'h0010_0000);
    // Ticks come every other edge; the 3072nd one lands 6142 or 6143 edges after enable.
    repeat (6143) @(posedge clock_i);
    #1 chk(n_cs, 0);
    repeat (2) @(posedge clock_i);
    #1 chk(n_cs, 1);
    wr(8'hE0, 32'h0040_0000);
    external_cycle_input_i <= 1'h1;
    @(posedge clock_i);
    external_cycle_input_i <= 1'h0;
    repeat (4) @(posedge clock_i);
    #1 chk(n_cs, 2);
    $display("timer test done");
    end_of_test;
  end
endmodule
